// ### clk_mode_pkg.sv
// constants, field layout and helpers for the system clock and low-power mode block
// assumes a 200 MHz bus clock and an axi4-lite register window of four words
package clk_mode_pkg;
	// ****************************************************
	// timing
	// ****************************************************
	localparam int CLK_MHZ = 200; // bus clock rate
	localparam int FRC_SETTLE_NS = 2000; // fast rc settle time, ns
	localparam int FXT_SETTLE_NS = 10000; // fast crystal settle time, ns
	localparam int SXT_SETTLE_NS = 20000; // slow crystal settle time, ns
	localparam int FRC_SETTLE_CYC = (FRC_SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int FXT_SETTLE_CYC = (FXT_SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int SXT_SETTLE_CYC = (SXT_SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int SETTLE_W = 12; // settle counter width
	// ****************************************************
	// register map
	// ****************************************************
	localparam int ADDR_W = 12;
	localparam logic [11:0] SYS_CLK_CONFIG_OFF = 12'h000;
	localparam logic [11:0] FAST_RC_CTRL_OFF = 12'h004;
	localparam logic [11:0] FAST_XTAL_CTRL_OFF = 12'h008;
	localparam logic [11:0] SLOW_XTAL_CTRL_OFF = 12'h00C;
	localparam logic [7:0] SYS_CLK_CONFIG_RST = 8'h00;
	localparam logic [7:0] FAST_RC_CTRL_RST = 8'h01;
	localparam logic [7:0] FAST_XTAL_CTRL_RST = 8'h00;
	localparam logic [7:0] SLOW_XTAL_CTRL_RST = 8'h00;
	// system clock config fields
	localparam int CKS_LSB = 5;
	localparam int FHS_BIT = 3;
	localparam int FSS_BIT = 2;
	localparam int FKEEP_BIT = 1;
	localparam int SKEEP_BIT = 0;
	// oscillator control fields
	localparam int FREQ_LSB = 2;
	localparam int RANGE_BIT = 2;
	localparam int STABLE_BIT = 1;
	localparam int EN_BIT = 0;
	localparam logic [2:0] CKS_SLOW = 3'h7; // select the slow clock
	localparam logic [1:0] RC_FREQ_ALIAS = 2'h3; // alias of the 8 MHz code
	localparam logic [1:0] RC_FREQ_8M = 2'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [5:0] DIV_ZERO = 6'h00;
	// ****************************************************
	// types and helpers
	// ****************************************************
	typedef enum logic [2:0] {
		MODE_RUN, MODE_SLEEP, MODE_SLOW_IDLE, MODE_DUAL_IDLE, MODE_FAST_IDLE
	} pwr_mode_e;
	// source edges per half period of the system clock, minus one
	function automatic logic [5:0] div_limit(input logic [2:0] code);
		if (code == CKS_SLOW) begin
			return DIV_ZERO;
		end
		return 6'((7'h01 << code) - 7'h01);
	endfunction
	// frequency code actually delivered to the rc trim
	function automatic logic [1:0] rc_freq_code(input logic [1:0] code);
		return (code == RC_FREQ_ALIAS) ? RC_FREQ_8M : code;
	endfunction
endpackage

// ### osc_pin_sync.sv
// synchroniser for an oscillator pin, gives a pulse on each agreed edge
// assumes the pin toggles slower than half the bus clock
`timescale 1ns/1ps
module osc_pin_sync (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pin,
	output logic edge_r
);
	logic s1_r; // first stage, read only by s2_r
	logic s2_r;
	logic s3_r;
	logic level_r; // last agreed level
	// three-stage capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	// a change counts once stages two and three agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			level_r <= 1'b0;
			edge_r <= 1'b0;
		end else begin
			edge_r <= (s2_r == s3_r) && (s3_r != level_r);
			if (s2_r == s3_r) begin
				level_r <= s3_r;
			end
		end
	end
endmodule

// ### osc_settle_timer.sv
// settle counter for one oscillator, drives its stable flag
// assumes run is a level from the same clock and restart a one-cycle pulse
`timescale 1ns/1ps
module osc_settle_timer #(
	parameter int CYCLES = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run,
	input wire logic restart,
	output logic stable_r
);
	import clk_mode_pkg::*;
	localparam logic [SETTLE_W-1:0] LAST = SETTLE_W'(CYCLES - 1);
	logic [SETTLE_W-1:0] cnt_r; // cycles since start
	// count from start or restart until the settle time has passed
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= '0;
			stable_r <= 1'b0;
		end else if (!run || restart) begin
			// stopped or retuned: flag drops at once
			cnt_r <= '0;
			stable_r <= 1'b0;
		end else if (!stable_r) begin
			if (cnt_r == LAST) begin
				stable_r <= 1'b1;
			end else begin
				cnt_r <= cnt_r + 1'b1;
			end
		end
	end
endmodule

// ### system_clock_mode_control.sv
// system clock select, oscillator control and halt modes behind axi4-lite
// assumes oscillator pins are asynchronous; halt and wake come from the cpu clock
//
// Functional notes
// - select code picks fast divided or slow
// - fast source: rc or crystal
// - slow source: rc or crystal
// - fast keep-alive keeps fast osc in halt
// - slow keep-alive keeps slow osc in halt
// - unimplemented bits read zero, ignore writes
// - rc frequency code 00/01/10/11 map
// - new rc frequency delivered once stable
// - rc enable or retune clears stable flag
// - rc enable resets to one
// - crystal range bit for crystal speed
// - range write blocked while crystal live
// - fast crystal enable restarts its flag
// - slow crystal enable restarts its flag
// - slow switch completes once source stable
// - halt with no keep-alive: sleep
// - halt with slow keep only: slow idle
// - halt sets power-down, clears timeout flag
// - halt clears watchdog counter
// - halt with both keeps: dual idle
// - halt with fast keep only: fast idle
`timescale 1ns/1ps
module system_clock_mode_control (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [clk_mode_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [clk_mode_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic internal_fast_rc,
	input wire logic external_fast_crystal,
	input wire logic internal_slow_rc,
	input wire logic external_slow_crystal,
	input wire logic crystal_pins,
	input wire logic halt_req,
	input wire logic wake_req,
	output logic sys_clk,
	output logic cpu_run,
	output logic fast_rc_on,
	output logic [1:0] fast_rc_trim,
	output logic fast_xtal_on,
	output logic slow_xtal_on,
	output logic crystal_range_bit,
	output logic fast_clk_on,
	output logic slow_clk_on,
	output logic power_down_set,
	output logic timeout_flag_clear,
	output logic watchdog_clear
);
	import clk_mode_pkg::*;
	// ****************************************************
	// state
	// ****************************************************
	logic [2:0] clock_select_field; // written select code
	logic fast_source_select; // 0 rc, 1 crystal
	logic slow_source_select; // 0 rc, 1 crystal
	logic fast_keep_alive;
	logic slow_keep_alive;
	logic [1:0] fast_rc_freq_field;
	logic fast_rc_enable;
	logic fast_crystal_enable;
	logic slow_crystal_enable;
	logic freq_chg_r; // rc retune pulse
	logic fast_rc_stable_flag;
	logic fast_crystal_stable_flag;
	logic slow_crystal_stable_flag;
	logic [2:0] app_cks_r; // select code in force
	logic app_fhs_r;
	logic app_fss_r;
	logic [5:0] div_cnt_r; // source edges in this half period
	pwr_mode_e mode_r;
	logic aw_got_r, w_got_r; // address and data held
	logic [ADDR_W-1:0] awaddr_r;
	logic [7:0] wbyte_r; // low byte of write data
	logic wlane_r; // low byte lane enabled
	logic fr_edge, fx_edge, sr_edge, sx_edge; // synced source edges
	logic halted, halt_take, write_fire, src_edge, apply_sel, slow_ok, clk_hold;
	logic [31:0] rd_word;
	logic rd_ok;
	assign halted = (mode_r != MODE_RUN);
	assign halt_take = halt_req && !halted;
	assign write_fire = aw_got_r && w_got_r && !bvalid;
	// ****************************************************
	// oscillator pins and settle timers
	// ****************************************************
	osc_pin_sync u_sync_frc (.aclk(aclk), .aresetn(aresetn), .pin(internal_fast_rc),
		.edge_r(fr_edge));
	osc_pin_sync u_sync_fxt (.aclk(aclk), .aresetn(aresetn), .pin(external_fast_crystal),
		.edge_r(fx_edge));
	osc_pin_sync u_sync_src (.aclk(aclk), .aresetn(aresetn), .pin(internal_slow_rc),
		.edge_r(sr_edge));
	osc_pin_sync u_sync_sxt (.aclk(aclk), .aresetn(aresetn), .pin(external_slow_crystal),
		.edge_r(sx_edge));
	// each timer restarts when its oscillator starts; the rc also on retune
	osc_settle_timer #(.CYCLES(FRC_SETTLE_CYC)) u_settle_frc (.aclk(aclk),
		.aresetn(aresetn), .run(fast_rc_on), .restart(freq_chg_r),
		.stable_r(fast_rc_stable_flag));
	osc_settle_timer #(.CYCLES(FXT_SETTLE_CYC)) u_settle_fxt (.aclk(aclk),
		.aresetn(aresetn), .run(fast_xtal_on), .restart(1'b0),
		.stable_r(fast_crystal_stable_flag));
	osc_settle_timer #(.CYCLES(SXT_SETTLE_CYC)) u_settle_sxt (.aclk(aclk),
		.aresetn(aresetn), .run(slow_xtal_on), .restart(1'b0),
		.stable_r(slow_crystal_stable_flag));
	// ****************************************************
	// register writes
	// ****************************************************
	// system clock config
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clock_select_field <= SYS_CLK_CONFIG_RST[CKS_LSB +: 3];
			fast_source_select <= SYS_CLK_CONFIG_RST[FHS_BIT];
			slow_source_select <= SYS_CLK_CONFIG_RST[FSS_BIT];
			fast_keep_alive <= SYS_CLK_CONFIG_RST[FKEEP_BIT];
			slow_keep_alive <= SYS_CLK_CONFIG_RST[SKEEP_BIT];
		end else if (write_fire && wlane_r && awaddr_r == SYS_CLK_CONFIG_OFF) begin
			clock_select_field <= wbyte_r[CKS_LSB +: 3];
			fast_source_select <= wbyte_r[FHS_BIT];
			slow_source_select <= wbyte_r[FSS_BIT];
			fast_keep_alive <= wbyte_r[FKEEP_BIT];
			slow_keep_alive <= wbyte_r[SKEEP_BIT];
		end
	end
	// fast rc control; a changed frequency code restarts the settle timer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fast_rc_freq_field <= FAST_RC_CTRL_RST[FREQ_LSB +: 2];
			fast_rc_enable <= FAST_RC_CTRL_RST[EN_BIT];
			freq_chg_r <= 1'b0;
		end else begin
			freq_chg_r <= 1'b0;
			if (write_fire && wlane_r && awaddr_r == FAST_RC_CTRL_OFF) begin
				fast_rc_freq_field <= wbyte_r[FREQ_LSB +: 2];
				fast_rc_enable <= wbyte_r[EN_BIT];
				freq_chg_r <= (wbyte_r[FREQ_LSB +: 2] != fast_rc_freq_field);
			end
		end
	end
	// crystal controls; range is frozen while the crystal pins are live and the fast crystal is enabled
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			crystal_range_bit <= FAST_XTAL_CTRL_RST[RANGE_BIT];
			fast_crystal_enable <= FAST_XTAL_CTRL_RST[EN_BIT];
			slow_crystal_enable <= SLOW_XTAL_CTRL_RST[EN_BIT];
		end else if (write_fire && wlane_r) begin
			if (awaddr_r == FAST_XTAL_CTRL_OFF) begin
				fast_crystal_enable <= wbyte_r[EN_BIT];
				if (!(crystal_pins && fast_crystal_enable)) begin
					crystal_range_bit <= wbyte_r[RANGE_BIT];
				end
			end
			if (awaddr_r == SLOW_XTAL_CTRL_OFF) begin
				slow_crystal_enable <= wbyte_r[EN_BIT];
			end
		end
	end
	// ****************************************************
	// oscillator run control
	// ****************************************************
	// oscillators stop in halt unless their keep-alive bit is set
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fast_rc_on <= 1'b0;
			fast_xtal_on <= 1'b0;
			slow_xtal_on <= 1'b0;
			fast_clk_on <= 1'b0;
			slow_clk_on <= 1'b0;
		end else begin
			fast_rc_on <= fast_rc_enable && (!halted || fast_keep_alive);
			fast_xtal_on <= fast_crystal_enable && (!halted || fast_keep_alive);
			slow_xtal_on <= slow_crystal_enable && (!halted || slow_keep_alive);
			fast_clk_on <= (fast_source_select ? fast_crystal_enable : fast_rc_enable)
				&& (!halted || fast_keep_alive);
			slow_clk_on <= !halted || slow_keep_alive;
		end
	end
	// the trim follows the new code only once the rc is stable; the retune pulse
	// masks the old flag, which still reads stable for one cycle after the write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fast_rc_trim <= rc_freq_code(FAST_RC_CTRL_RST[FREQ_LSB +: 2]);
		end else if (fast_rc_stable_flag && !freq_chg_r) begin
			fast_rc_trim <= rc_freq_code(fast_rc_freq_field);
		end
	end
	// ****************************************************
	// system clock generation
	// ****************************************************
	// edge of the source in force; a stopped oscillator gives no edges
	always_comb begin
		if (app_cks_r == CKS_SLOW) begin
			src_edge = app_fss_r ? (sx_edge && slow_xtal_on) : sr_edge;
		end else begin
			src_edge = app_fhs_r ? (fx_edge && fast_xtal_on) : (fr_edge && fast_rc_on);
		end
	end
	assign slow_ok = slow_source_select ? slow_crystal_stable_flag : 1'b1;
	// a new selection is taken only in the low phase, slow only once stable
	assign apply_sel = !sys_clk &&
		({clock_select_field, fast_source_select, slow_source_select}
		!= {app_cks_r, app_fhs_r, app_fss_r}) &&
		(clock_select_field != CKS_SLOW || slow_ok);
	// in halt the clock stops unless its source is kept alive
	assign clk_hold = halted &&
		!((app_cks_r == CKS_SLOW) ? slow_keep_alive : fast_keep_alive);
	// selection in force
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			app_cks_r <= SYS_CLK_CONFIG_RST[CKS_LSB +: 3];
			app_fhs_r <= SYS_CLK_CONFIG_RST[FHS_BIT];
			app_fss_r <= SYS_CLK_CONFIG_RST[FSS_BIT];
		end else if (apply_sel) begin
			app_cks_r <= clock_select_field;
			app_fhs_r <= fast_source_select;
			app_fss_r <= slow_source_select;
		end
	end
	// divider: 2^code source periods per output period; the slow code gives one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_cnt_r <= '0;
		end else if (apply_sel) begin
			div_cnt_r <= '0;
		end else if (src_edge) begin
			if (div_cnt_r == div_limit(app_cks_r)) begin
				div_cnt_r <= '0;
			end else begin
				div_cnt_r <= div_cnt_r + 1'b1;
			end
		end
	end
	// output toggles at the divider end; a held clock finishes its high phase
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sys_clk <= 1'b0;
		end else if (!apply_sel && src_edge && div_cnt_r == div_limit(app_cks_r)
			&& !(clk_hold && !sys_clk)) begin
			sys_clk <= !sys_clk;
		end
	end
	// ****************************************************
	// halt modes
	// ****************************************************
	// keep-alive bits choose the halted mode; wake returns to run
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_r <= MODE_RUN;
		end else begin
			case (mode_r)
				MODE_RUN: begin
					if (halt_req) begin
						case ({fast_keep_alive, slow_keep_alive})
							2'b00: mode_r <= MODE_SLEEP;
							2'b01: mode_r <= MODE_SLOW_IDLE;
							2'b11: mode_r <= MODE_DUAL_IDLE;
							default: mode_r <= MODE_FAST_IDLE;
						endcase
					end
				end
				default: begin
					if (wake_req) begin
						mode_r <= MODE_RUN;
					end
				end
			endcase
		end
	end
	// cpu stops; status and watchdog pulses on entry, registers untouched
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cpu_run <= 1'b0;
			power_down_set <= 1'b0;
			timeout_flag_clear <= 1'b0;
			watchdog_clear <= 1'b0;
		end else begin
			cpu_run <= !(halted ? !wake_req : halt_req);
			power_down_set <= halt_take;
			timeout_flag_clear <= halt_take;
			watchdog_clear <= halt_take;
		end
	end
	// ****************************************************
	// axi4-lite slave
	// ****************************************************
	// write address and data are held until both are in
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			aw_got_r <= 1'b0;
			awaddr_r <= '0;
		end else if (awvalid && awready) begin
			awready <= 1'b0;
			aw_got_r <= 1'b1;
			awaddr_r <= awaddr;
		end else begin
			if (write_fire) begin
				aw_got_r <= 1'b0;
			end
			awready <= !aw_got_r && !bvalid;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready <= 1'b0;
			w_got_r <= 1'b0;
			wbyte_r <= '0;
			wlane_r <= 1'b0;
		end else if (wvalid && wready) begin
			wready <= 1'b0;
			w_got_r <= 1'b1;
			wbyte_r <= wdata[7:0];
			wlane_r <= wstrb[0];
		end else begin
			if (write_fire) begin
				w_got_r <= 1'b0;
			end
			wready <= !w_got_r && !bvalid;
		end
	end
	// response; an address outside the map answers slverr
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (write_fire) begin
			bvalid <= 1'b1;
			bresp <= (awaddr_r == SYS_CLK_CONFIG_OFF || awaddr_r == FAST_RC_CTRL_OFF
				|| awaddr_r == FAST_XTAL_CTRL_OFF || awaddr_r == SLOW_XTAL_CTRL_OFF)
				? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end
	// read mux; unimplemented bits read zero
	always_comb begin
		rd_word = '0;
		rd_ok = 1'b1;
		case (araddr)
			SYS_CLK_CONFIG_OFF: rd_word[7:0] = {clock_select_field, 1'b0, fast_source_select,
				slow_source_select, fast_keep_alive, slow_keep_alive};
			FAST_RC_CTRL_OFF: rd_word[3:0] = {fast_rc_freq_field, fast_rc_stable_flag,
				fast_rc_enable};
			FAST_XTAL_CTRL_OFF: rd_word[2:0] = {crystal_range_bit, fast_crystal_stable_flag,
				fast_crystal_enable};
			SLOW_XTAL_CTRL_OFF: rd_word[1:0] = {slow_crystal_stable_flag, slow_crystal_enable};
			default: rd_ok = 1'b0;
		endcase
	end
	// read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_word;
			rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else begin
			if (rready) begin
				rvalid <= 1'b0;
			end
			arready <= !rvalid;
		end
	end
	// ****************************************************
	// checks
	// ****************************************************
	a_slow_waits_stable: assert property (@(posedge aclk) disable iff (!aresetn)
		$changed(app_cks_r) && app_cks_r == CKS_SLOW |-> $past(slow_ok))
		else $error("slow clock taken before its source was stable");
	a_switch_low_phase: assert property (@(posedge aclk) disable iff (!aresetn)
		$changed({app_cks_r, app_fhs_r, app_fss_r}) |-> !sys_clk && !$past(sys_clk))
		else $error("clock selection changed outside the low phase");
	a_divider_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
		$changed(sys_clk) |-> $past(src_edge && div_cnt_r == div_limit(app_cks_r)))
		else $error("system clock toggled off the divider boundary");
	a_halt_pulses: assert property (@(posedge aclk) disable iff (!aresetn)
		halt_take |=> power_down_set && timeout_flag_clear && watchdog_clear && !cpu_run
		##1 !power_down_set && !watchdog_clear)
		else $error("halt entry pulses wrong");
	a_sleep_entry: assert property (@(posedge aclk) disable iff (!aresetn)
		halt_take && !fast_keep_alive && !slow_keep_alive |=> mode_r == MODE_SLEEP
		##1 !fast_rc_on && !fast_xtal_on && !slow_xtal_on && !slow_clk_on)
		else $error("sleep entry wrong");
	a_slow_idle: assert property (@(posedge aclk) disable iff (!aresetn)
		halt_take && !fast_keep_alive && slow_keep_alive |=> mode_r == MODE_SLOW_IDLE
		##1 !fast_clk_on && slow_clk_on && slow_xtal_on == slow_crystal_enable)
		else $error("slow idle entry wrong");
	a_dual_idle: assert property (@(posedge aclk) disable iff (!aresetn)
		halt_take && fast_keep_alive && slow_keep_alive |=> mode_r == MODE_DUAL_IDLE
		##1 slow_clk_on && fast_rc_on == fast_rc_enable)
		else $error("dual idle entry wrong");
	a_fast_idle: assert property (@(posedge aclk) disable iff (!aresetn)
		halt_take && fast_keep_alive && !slow_keep_alive |=> mode_r == MODE_FAST_IDLE
		##1 !slow_clk_on && !slow_xtal_on && fast_rc_on == fast_rc_enable)
		else $error("fast idle entry wrong");
	a_range_locked: assert property (@(posedge aclk) disable iff (!aresetn)
		write_fire && awaddr_r == FAST_XTAL_CTRL_OFF && crystal_pins && fast_crystal_enable
		|=> $stable(crystal_range_bit))
		else $error("crystal range changed while locked");
	a_trim_when_stable: assert property (@(posedge aclk) disable iff (!aresetn)
		$changed(fast_rc_trim) |-> $past(fast_rc_stable_flag) && !$past(freq_chg_r))
		else $error("rc trim changed while unstable");
	c_sleep: cover property (@(posedge aclk) disable iff (!aresetn)
		halt_take ##1 mode_r == MODE_SLEEP ##[1:50] mode_r == MODE_RUN);
	c_to_slow: cover property (@(posedge aclk) disable iff (!aresetn)
		$changed(app_cks_r) && app_cks_r == CKS_SLOW);
	c_range_blocked: cover property (@(posedge aclk) disable iff (!aresetn)
		write_fire && awaddr_r == FAST_XTAL_CTRL_OFF && crystal_pins && fast_crystal_enable);
endmodule

// ### osc_source.sv
// free-running oscillator pin model for the clock mode block
// assumes aclk at 200 MHz; every pin level lasts at least 4 aclk cycles
`timescale 1ns/1ps
module osc_source (
	input wire logic aclk,
	output logic internal_fast_rc,
	output logic external_fast_crystal,
	output logic internal_slow_rc,
	output logic external_slow_crystal
);
	// ****************************************************
	// oscillator edges
	// ****************************************************
	logic [7:0] cnt_r = 8'h00; // divides aclk into the four pin rates
	// each pin runs free, so the synchronisers always see real edges
	always @(posedge aclk) begin
		cnt_r <= cnt_r + 8'h01;
	end
	assign internal_fast_rc = cnt_r[2];
	assign external_fast_crystal = cnt_r[3];
	assign internal_slow_rc = cnt_r[5];
	assign external_slow_crystal = cnt_r[6];
endmodule

// ### tb.sv
// self-checking bench for the clock mode block
// assumes a 200 MHz clock; reads and writes go through axi4-lite tasks
`timescale 1ns/1ps
module tb;
	import clk_mode_pkg::*;
	logic aclk = 0, aresetn, awvalid, wvalid, bready, arvalid, rready, crystal_pins, halt_req;
	logic wake_req, awready, wready, bvalid, arready, rvalid, sys_clk, cpu_run, fast_rc_on;
	logic fast_xtal_on, slow_xtal_on, crystal_range_bit, fast_clk_on, slow_clk_on;
	logic power_down_set, timeout_flag_clear, watchdog_clear;
	logic internal_fast_rc, external_fast_crystal, internal_slow_rc, external_slow_crystal;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, fast_rc_trim, prev, fc;
	logic [1:0] wq[$]; // expected write responses
	logic [33:0] rq[$]; // expected read response and data
	logic [33:0] cnt; // system clock rises in a window
	int n_fail = 0, n_compared = 0, n_cyc = 0;
	system_clock_mode_control system_clock_mode_control_i (.*);
	osc_source osc_source_i (.*);
	// ****************************************************
	// clock, timeout, checking
	// ****************************************************
	always #2.5 aclk = ~aclk;
	task automatic chk(input logic [33:0] s, input logic [33:0] x);
		n_compared++;
		if (s !== x) begin
			n_fail++;
			$display("Error at %0t: got %h want %h", $time, s, x);
		end
	endtask
	task close_out;
		if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// cuts a hang short
	always @(posedge aclk) begin
		n_cyc++;
		if (n_cyc == 30000) begin
			n_fail++;
			close_out;
		end
	end
	// compares each bus answer with the oldest noted expectation
	always @(posedge aclk) begin
		if (bvalid && bready) chk(34'(bresp), 34'(wq.pop_front()));
		if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
	end
	// ****************************************************
	// bus tasks
	// ****************************************************
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] e);
		bit ad, wd;
		ad = 0;
		wd = 0;
		wq.push_back(e);
		awaddr <= a;
		wdata <= {24'($urandom()), d};
		awvalid <= 1;
		wvalid <= 1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (awready && !ad) begin ad = 1; awvalid <= 0; end
			if (wready && !wd) begin wd = 1; wvalid <= 0; end
		end
		do @(posedge aclk); while (!bvalid);
	endtask
	// counts rising edges of the system clock over n bus cycles
	task automatic rises(input int n, output logic [33:0] c);
		logic last;
		c = '0;
		last = sys_clk;
		repeat (n) begin
			@(posedge aclk);
			if (sys_clk && !last) c = c + 34'h1;
			last = sys_clk;
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] e);
		rq.push_back({e, 24'h0, d});
		araddr <= a;
		arvalid <= 1;
		do @(posedge aclk); while (!arready);
		arvalid <= 0;
		do @(posedge aclk); while (!rvalid);
	endtask
	// ****************************************************
	// main sequence
	// ****************************************************
	initial begin
		{awvalid, wvalid, arvalid, crystal_pins, halt_req, wake_req, aresetn} = '0;
		{bready, rready, wstrb, awaddr, araddr, wdata} = {2'h3, 4'hF, 56'h0};
		void'($urandom(79899));
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		repeat (2) @(posedge aclk);
		rd(SYS_CLK_CONFIG_OFF, 8'h00, RESP_OKAY);
		rd(FAST_RC_CTRL_OFF, 8'h01, RESP_OKAY);
		rd(FAST_XTAL_CTRL_OFF, 8'h00, RESP_OKAY);
		wr(SYS_CLK_CONFIG_OFF, 8'hFF, RESP_OKAY);
		rd(SYS_CLK_CONFIG_OFF, 8'hEF, RESP_OKAY);
		wr(12'h010, 8'hA5, RESP_SLVERR);
		rd(12'h010, 8'h00, RESP_SLVERR);
		prev = 2'h0;
		for (int f = 1; f < 5; f++) begin
			fc = 2'(f);
			wr(FAST_RC_CTRL_OFF, {4'h0, fc, 2'h1}, RESP_OKAY);
			#1 chk(34'(fast_rc_trim), 34'(prev));
			rd(FAST_RC_CTRL_OFF, {4'h0, fc, 2'h1}, RESP_OKAY);
			repeat (FRC_SETTLE_CYC + 20) @(posedge aclk);
			prev = (fc == 2'h3) ? 2'h0 : fc;
			#1 chk(34'(fast_rc_trim), 34'(prev));
			rd(FAST_RC_CTRL_OFF, {4'h0, fc, 2'h3}, RESP_OKAY);
		end
		crystal_pins <= 1;
		wr(FAST_XTAL_CTRL_OFF, 8'h04, RESP_OKAY);
		wr(FAST_XTAL_CTRL_OFF, 8'h05, RESP_OKAY);
		wr(FAST_XTAL_CTRL_OFF, 8'h01, RESP_OKAY);
		#1 chk(34'(crystal_range_bit), 34'h1);
		chk(34'(fast_xtal_on), 34'h1);
		rd(FAST_XTAL_CTRL_OFF, 8'h05, RESP_OKAY);
		repeat (FXT_SETTLE_CYC + 20) @(posedge aclk);
		rd(FAST_XTAL_CTRL_OFF, 8'h07, RESP_OKAY);
		crystal_pins <= 0;
		wr(FAST_XTAL_CTRL_OFF, 8'h01, RESP_OKAY);
		rd(FAST_XTAL_CTRL_OFF, 8'h03, RESP_OKAY);
		wr(FAST_XTAL_CTRL_OFF, 8'h00, RESP_OKAY);
		#1 chk(34'(fast_xtal_on), 34'h0);
		wr(SLOW_XTAL_CTRL_OFF, 8'h01, RESP_OKAY);
		#1 chk(34'(slow_xtal_on), 34'h1);
		rd(SLOW_XTAL_CTRL_OFF, 8'h01, RESP_OKAY);
		repeat (SXT_SETTLE_CYC + 20) @(posedge aclk);
		rd(SLOW_XTAL_CTRL_OFF, 8'h03, RESP_OKAY);
		// every keep-alive pairing gives its own halted mode
		for (int k = 0; k < 4; k++) begin
			wr(SYS_CLK_CONFIG_OFF, {6'h0, 2'(k)}, RESP_OKAY);
			halt_req <= 1;
			@(posedge aclk);
			halt_req <= 0;
			#1 chk(34'(cpu_run), 34'h0);
			chk(34'({power_down_set, timeout_flag_clear, watchdog_clear}), 34'h7);
			@(posedge aclk);
			#1 chk(34'({fast_clk_on, slow_clk_on}), 34'(k));
			chk(34'(fast_rc_on), 34'(k >> 1));
			wake_req <= 1;
			@(posedge aclk);
			wake_req <= 0;
			#1 chk(34'(cpu_run), 34'h1);
			rd(SYS_CLK_CONFIG_OFF, {6'h0, 2'(k)}, RESP_OKAY);
		end
		// rc pin period is 8 cycles: code 2 gives 32, the slow rc pin gives 64
		wr(SYS_CLK_CONFIG_OFF, 8'h40, RESP_OKAY);
		repeat (64) @(posedge aclk);
		rises(256, cnt);
		chk(cnt, 34'h8);
		wr(SYS_CLK_CONFIG_OFF, 8'hE0, RESP_OKAY);
		repeat (128) @(posedge aclk);
		rises(256, cnt);
		chk(cnt, 34'h4);
		// back to fast: software sees the rc settled again after its halts
		wr(SYS_CLK_CONFIG_OFF, 8'h00, RESP_OKAY);
		rd(FAST_RC_CTRL_OFF, 8'h03, RESP_OKAY);
		repeat (4) @(posedge aclk);
		close_out;
	end
endmodule
